//--- inc/dtc_defines.vh
// Register map, field positions, reset values and mode codes of the
// dual timer/counter. Definitions only; included by the timer core.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register byte addresses
`define DTC_ADR_CTRL      8'h88
`define DTC_ADR_MODE      8'h89
`define DTC_ADR_LOW0      8'h8a
`define DTC_ADR_LOW1      8'h8b
`define DTC_ADR_HIGH0     8'h8c
`define DTC_ADR_HIGH1     8'h8d
`define DTC_ADR_EXTRA     8'h91
`define DTC_ADR_RLDL0     8'h92
`define DTC_ADR_RLDL1     8'h93
`define DTC_ADR_RLDH0     8'h94
`define DTC_ADR_RLDH1     8'h95

// Control/status bit positions
`define DTC_CS_OVF1       7
`define DTC_CS_RUN1       6
`define DTC_CS_OVF0       5
`define DTC_CS_RUN0       4
`define DTC_CS_XF1        3
`define DTC_CS_XT1        2
`define DTC_CS_XF0        1
`define DTC_CS_XT0        0

// Mode register field positions, timer 1 nibble is 7..4
`define DTC_MD_GATE       3
`define DTC_MD_CNT        2
`define DTC_MD_HI         1
`define DTC_MD_LO         0

// Mode codes
`define DTC_MODE_VAR      2'b00
`define DTC_MODE_R16      2'b01
`define DTC_MODE_R8       2'b10
`define DTC_MODE_SPLIT    2'b11

// Reset values
`define DTC_RST_CTRL      8'h00
`define DTC_RST_MODE      8'h00
`define DTC_RST_EXTRA     8'h24
`define DTC_RST_RELOAD    8'h00

`endif

//--- src/dtc_timer.v
// Dual timer/counter core with control/status, mode and count registers,
// reached as a classic Wishbone slave with an 8-bit register data path.
// Assumes count and gate pins are already synchronous to clk_i.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "dtc_defines.vh"

module dtc_timer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        count_input_0_i,
    input  wire        count_input_1_i,
    input  wire        ext_irq_pin_0_i,
    input  wire        ext_irq_pin_1_i,
    input  wire        irq_ack_ovf0_i,
    input  wire        irq_ack_ovf1_i,
    input  wire        irq_ack_ext0_i,
    input  wire        irq_ack_ext1_i,
    output wire        overflow_flag_0_o,
    output wire        overflow_flag_1_o,
    output wire        ext_irq_flag_0_o,
    output wire        ext_irq_flag_1_o,
    output wire        baud_tick_o
);

    reg  [7:0] ctrl_q;
    reg  [7:0] mode_q;
    reg  [7:0] extra_q;
    reg  [7:0] low0_q;
    reg  [7:0] low1_q;
    reg  [7:0] high0_q;
    reg  [7:0] high1_q;
    reg  [7:0] rldl0_q;
    reg  [7:0] rldl1_q;
    reg  [7:0] rldh0_q;
    reg  [7:0] rldh1_q;
    reg        cin0_q;
    reg        cin1_q;
    reg        xin0_q;
    reg        xin1_q;
    reg  [7:0] ctrl_d;
    reg  [7:0] low0_d;
    reg  [7:0] low1_d;
    reg  [7:0] high0_d;
    reg  [7:0] high1_d;
    reg        ovf0_set;
    reg        ovf1_set;
    reg        t1_ovf;

    wire       wr_stb  = cyc_i & stb_i & we_i & sel_i[0] & ~ack_o;
    wire       rd_stb  = cyc_i & stb_i & ~ack_o;
    wire [1:0] mode0   = mode_q[`DTC_MD_HI:`DTC_MD_LO];
    wire [1:0] mode1   = mode_q[`DTC_MD_HI+4:`DTC_MD_LO+4];

    // Counter-source falling edge: high sample then low sample
    wire       cedge0  = cin0_q & ~count_input_0_i;
    wire       cedge1  = cin1_q & ~count_input_1_i;

    // Pick clock or pin edge as count event
    wire       src0    = mode_q[`DTC_MD_CNT] ? cedge0 : 1'b1;
    wire       src1    = mode_q[`DTC_MD_CNT+4] ? cedge1 : 1'b1;

    // Run and gate qualify each count but the split high byte
    wire       en0     = ctrl_q[`DTC_CS_RUN0] &
                         (~mode_q[`DTC_MD_GATE] | ext_irq_pin_0_i);
    wire       en1     = ctrl_q[`DTC_CS_RUN1] &
                         (~mode_q[`DTC_MD_GATE+4] | ext_irq_pin_1_i);
    wire       cnt0    = en0 & src0;
    wire       cnt1    = en1 & src1 & (mode1 != `DTC_MODE_SPLIT);
    // Split high byte: clocks only, timer 1 run bit
    wire       cnt0h   = ctrl_q[`DTC_CS_RUN1];

    wire [2:0] psel0   = extra_q[2:0];
    wire [2:0] psel1   = extra_q[5:3];

    wire [7:0] vs0_hi;
    wire [7:0] vs0_lo;
    wire       vs0_ovf;
    wire [7:0] vs1_hi;
    wire [7:0] vs1_lo;
    wire       vs1_ovf;

    // Timer 0 variable-width prescaled step
    dtc_var_step i_dtc_var_step_0 (
        .hi_i  (high0_q),
        .lo_i  (low0_q),
        .sel_i (psel0),
        .hi_o  (vs0_hi),
        .lo_o  (vs0_lo),
        .ovf_o (vs0_ovf)
    );

    // Timer 1 variable-width prescaled step
    dtc_var_step i_dtc_var_step_1 (
        .hi_i  (high1_q),
        .lo_i  (low1_q),
        .sel_i (psel1),
        .hi_o  (vs1_hi),
        .lo_o  (vs1_lo),
        .ovf_o (vs1_ovf)
    );

    // Counting for timer 0, all modes
    always @* begin
        low0_d   = low0_q;
        high0_d  = high0_q;
        ovf0_set = 1'b0;
        ovf1_set = 1'b0;
        case (mode0)
            `DTC_MODE_VAR: begin
                if (cnt0) begin
                    high0_d  = vs0_hi;
                    low0_d   = vs0_lo;
                    ovf0_set = vs0_ovf;
                end
            end
            `DTC_MODE_R16: begin
                if (cnt0) begin
                    if ({high0_q, low0_q} == 16'hffff) begin
                        high0_d  = rldh0_q;
                        low0_d   = rldl0_q;
                        ovf0_set = 1'b1;
                    end else begin
                        {high0_d, low0_d} = {high0_q, low0_q} + 16'h0001;
                    end
                end
            end
            `DTC_MODE_R8: begin
                if (cnt0) begin
                    if (low0_q == 8'hff) begin
                        low0_d   = high0_q;
                        ovf0_set = 1'b1;
                    end else begin
                        low0_d = low0_q + 8'h01;
                    end
                end
            end
            default: begin
                // Split: two independent 8-bit timers
                if (cnt0) begin
                    low0_d   = low0_q + 8'h01;
                    ovf0_set = (low0_q == 8'hff);
                end
                if (cnt0h) begin
                    high0_d  = high0_q + 8'h01;
                    ovf1_set = (high0_q == 8'hff);
                end
            end
        endcase
    end

    // Counting for timer 1; overflow still feeds the baud tick
    always @* begin
        low1_d  = low1_q;
        high1_d = high1_q;
        t1_ovf  = 1'b0;
        case (mode1)
            `DTC_MODE_VAR: begin
                if (cnt1) begin
                    high1_d = vs1_hi;
                    low1_d  = vs1_lo;
                    t1_ovf  = vs1_ovf;
                end
            end
            `DTC_MODE_R16: begin
                if (cnt1) begin
                    if ({high1_q, low1_q} == 16'hffff) begin
                        high1_d = rldh1_q;
                        low1_d  = rldl1_q;
                        t1_ovf  = 1'b1;
                    end else begin
                        {high1_d, low1_d} = {high1_q, low1_q} + 16'h0001;
                    end
                end
            end
            `DTC_MODE_R8: begin
                if (cnt1) begin
                    if (low1_q == 8'hff) begin
                        low1_d = high1_q;
                        t1_ovf = 1'b1;
                    end else begin
                        low1_d = low1_q + 8'h01;
                    end
                end
            end
            default: begin
                t1_ovf = 1'b0; // holds count
            end
        endcase
    end

    assign baud_tick_o = t1_ovf;

    // Flag next state: write, then hardware clear, then hardware set
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_stb && adr_i == `DTC_ADR_CTRL) begin
            ctrl_d = dat_i[7:0];
        end
        if (irq_ack_ovf0_i) begin
            ctrl_d[`DTC_CS_OVF0] = 1'b0;
        end
        if (irq_ack_ovf1_i) begin
            ctrl_d[`DTC_CS_OVF1] = 1'b0;
        end
        if (irq_ack_ext0_i && ctrl_q[`DTC_CS_XT0]) begin
            ctrl_d[`DTC_CS_XF0] = 1'b0;
        end
        if (irq_ack_ext1_i && ctrl_q[`DTC_CS_XT1]) begin
            ctrl_d[`DTC_CS_XF1] = 1'b0;
        end
        if (ovf0_set) begin
            ctrl_d[`DTC_CS_OVF0] = 1'b1;
        end
        // Timer 1 flag owned by split high byte in timer 0 mode 3
        if (mode0 == `DTC_MODE_SPLIT ? ovf1_set : t1_ovf) begin
            ctrl_d[`DTC_CS_OVF1] = 1'b1;
        end
        // External flags by type bit
        if (ctrl_q[`DTC_CS_XT0]) begin
            if (xin0_q & ~ext_irq_pin_0_i) begin
                ctrl_d[`DTC_CS_XF0] = 1'b1;
            end
        end else begin
            ctrl_d[`DTC_CS_XF0] = ~ext_irq_pin_0_i;
        end
        if (ctrl_q[`DTC_CS_XT1]) begin
            if (xin1_q & ~ext_irq_pin_1_i) begin
                ctrl_d[`DTC_CS_XF1] = 1'b1;
            end
        end else begin
            ctrl_d[`DTC_CS_XF1] = ~ext_irq_pin_1_i;
        end
    end

    // Registers; software writes override the count in that cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= `DTC_RST_CTRL;
            mode_q  <= `DTC_RST_MODE;
            extra_q <= `DTC_RST_EXTRA;
            low0_q  <= 8'h00;
            low1_q  <= 8'h00;
            high0_q <= 8'h00;
            high1_q <= 8'h00;
            rldl0_q <= `DTC_RST_RELOAD;
            rldl1_q <= `DTC_RST_RELOAD;
            rldh0_q <= `DTC_RST_RELOAD;
            rldh1_q <= `DTC_RST_RELOAD;
            cin0_q  <= 1'b0;
            cin1_q  <= 1'b0;
            xin0_q  <= 1'b0;
            xin1_q  <= 1'b0;
        end else begin
            cin0_q  <= count_input_0_i;
            cin1_q  <= count_input_1_i;
            xin0_q  <= ext_irq_pin_0_i;
            xin1_q  <= ext_irq_pin_1_i;
            ctrl_q  <= ctrl_d;
            low0_q  <= low0_d;
            low1_q  <= low1_d;
            high0_q <= high0_d;
            high1_q <= high1_d;
            if (wr_stb) begin
                case (adr_i)
                    `DTC_ADR_MODE:  mode_q  <= dat_i[7:0];
                    `DTC_ADR_EXTRA: extra_q <= dat_i[7:0];
                    `DTC_ADR_LOW0:  low0_q  <= dat_i[7:0];
                    `DTC_ADR_LOW1:  low1_q  <= dat_i[7:0];
                    `DTC_ADR_HIGH0: high0_q <= dat_i[7:0];
                    `DTC_ADR_HIGH1: high1_q <= dat_i[7:0];
                    `DTC_ADR_RLDL0: rldl0_q <= dat_i[7:0];
                    `DTC_ADR_RLDL1: rldl1_q <= dat_i[7:0];
                    `DTC_ADR_RLDH0: rldh0_q <= dat_i[7:0];
                    `DTC_ADR_RLDH1: rldh1_q <= dat_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    assign overflow_flag_0_o = ctrl_q[`DTC_CS_OVF0];
    assign overflow_flag_1_o = ctrl_q[`DTC_CS_OVF1];
    assign ext_irq_flag_0_o  = ctrl_q[`DTC_CS_XF0];
    assign ext_irq_flag_1_o  = ctrl_q[`DTC_CS_XF1];

    // Bus answer: one-cycle ack, registered read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= rd_stb;
            dat_o <= 32'h0000_0000;
            if (rd_stb && !we_i) begin
                case (adr_i)
                    `DTC_ADR_CTRL:  dat_o[7:0] <= ctrl_q;
                    `DTC_ADR_MODE:  dat_o[7:0] <= mode_q;
                    `DTC_ADR_EXTRA: dat_o[7:0] <= extra_q;
                    `DTC_ADR_LOW0:  dat_o[7:0] <= low0_q;
                    `DTC_ADR_LOW1:  dat_o[7:0] <= low1_q;
                    `DTC_ADR_HIGH0: dat_o[7:0] <= high0_q;
                    `DTC_ADR_HIGH1: dat_o[7:0] <= high1_q;
                    `DTC_ADR_RLDL0: dat_o[7:0] <= rldl0_q;
                    `DTC_ADR_RLDL1: dat_o[7:0] <= rldl1_q;
                    `DTC_ADR_RLDH0: dat_o[7:0] <= rldh0_q;
                    `DTC_ADR_RLDH1: dat_o[7:0] <= rldh1_q;
                    default:        dat_o[7:0] <= 8'h00;
                endcase
            end
        end
    end

endmodule // dtc_timer

// Mode 0 step: low-byte prescaler of 1..8 active bits feeding the
// high byte; carry into the high byte only when all active bits are ones
module dtc_var_step (
    input  wire [7:0] hi_i,
    input  wire [7:0] lo_i,
    input  wire [2:0] sel_i,
    output reg  [7:0] hi_o,
    output reg  [7:0] lo_o,
    output reg        ovf_o
);

    reg  [7:0] mask;
    reg  [7:0] lon;

    // Bits above the active width keep their value
    always @* begin
        mask  = 8'hff >> (3'd7 - sel_i);
        lon   = (lo_i & mask) + 8'h01;
        lo_o  = (lo_i & ~mask) | (lon & mask);
        hi_o  = hi_i;
        ovf_o = 1'b0;
        if ((lo_i & mask) == mask) begin
            hi_o  = hi_i + 8'h01;
            ovf_o = (hi_i == 8'hff);
        end
    end

endmodule // dtc_var_step

//--- bench/dtc_pins_model.sv
// Pin model for timer 0 count input and external interrupt 0 pin.
// Assumes calls start just after a rising edge of clk_i.
`timescale 1ns/10ps
module dtc_pins_model (
    input  wire  clk_i,
    output logic count_input_0_o,
    output logic ext_irq_pin_0_o
);
    // Idle lines sit high
    initial begin
        count_input_0_o = 1'b1;
        ext_irq_pin_0_o = 1'b1;
    end
    // Set gate pin level
    task set(input logic v);
        ext_irq_pin_0_o <= v;
    endtask
    // Gate open for n sampled clocks, then closed
    task gate(input int n);
        ext_irq_pin_0_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        ext_irq_pin_0_o <= 1'b0;
    endtask
    // Falling edges, each level held one clock
    task pulses(input int n);
        repeat (n) begin
            count_input_0_o <= 1'b0;
            @(posedge clk_i);
            count_input_0_o <= 1'b1;
            @(posedge clk_i);
        end
    endtask
    // High, low, high again, two clocks or more each
    task fall;
        ext_irq_pin_0_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        ext_irq_pin_0_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        ext_irq_pin_0_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // dtc_pins_model

//--- bench/dtc_timer_chk.sv
// Port checker for the dual timer/counter.
// Sees only timer ports; bound to every dtc_timer.
`timescale 1ns/10ps
module dtc_timer_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        ext_irq_pin_0_i,
    input wire        irq_ack_ext0_i,
    input wire        ext_irq_flag_0_o,
    input wire        overflow_flag_1_o,
    input wire        baud_tick_o
);
    wire acc_w = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    wire wcs_w = acc_w && adr_i == 8'h88;
    logic [7:0] md_q;
    logic       xt_q;
    // Shadow of mode register and type bit 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            md_q <= 8'h00;
            xt_q <= 1'b0;
        end else if (wcs_w) begin
            xt_q <= dat_i[0];
        end else if (acc_w && adr_i == 8'h89) begin
            md_q <= dat_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside answer");
    chk_dat_width: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits");
    chk_level_follow: assert property (
        !$past(xt_q) && !$past(wcs_w) && !$past(rst_i)
        |-> ext_irq_flag_0_o == !$past(ext_irq_pin_0_i))
        else $error("level flag not following pin");
    chk_edge_set: assert property (
        $past(xt_q) && xt_q && $past(ext_irq_pin_0_i, 2)
        && !$past(ext_irq_pin_0_i) && !$past(rst_i) && !$past(rst_i, 2)
        |-> ##[0:1] ext_irq_flag_0_o)
        else $error("falling edge missed");
    chk_edge_clear: assert property (
        $past(irq_ack_ext0_i) && $past(xt_q) && xt_q && !$past(wcs_w)
        && $past(ext_irq_pin_0_i) && $past(ext_irq_pin_0_i, 2)
        && $past(ext_irq_pin_0_i, 3) && !$past(rst_i)
        |-> !ext_irq_flag_0_o)
        else $error("edge flag not cleared");
    chk_baud_flag: assert property (
        baud_tick_o && md_q[1:0] != 2'b11 |=> overflow_flag_1_o)
        else $error("overflow flag 1 not set");
    chk_t1_hold: assert property (md_q[5:4] == 2'b11 |-> !baud_tick_o)
        else $error("timer 1 overflow in mode 3");
endmodule // dtc_timer_chk

bind dtc_timer dtc_timer_chk i_dtc_timer_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_irq_pin_0_i(ext_irq_pin_0_i),
    .irq_ack_ext0_i(irq_ack_ext0_i), .ext_irq_flag_0_o(ext_irq_flag_0_o),
    .overflow_flag_1_o(overflow_flag_1_o), .baud_tick_o(baud_tick_o));

//--- bench/tb.sv
// Self-checking bench for the dual timer/counter.
// Classic Wishbone master; timer 1 pins and acks driven by the bench.
`timescale 1ns/10ps
module tb;
    logic        clk_i, rst_i, cyc, stb, we, a_ovf0, a_ext0;
    logic [7:0]  adr, d;
    logic [31:0] dat_i;
    wire  [31:0] dat_o;
    logic        cnt1, irq1, a_ovf1, a_ext1;
    logic [3:0]  sel;
    wire         ack_o, cnt0, irq0, ovf0, ovf1, xf0, xf1, btk;
    int          errors, checks_done;
    int          ticks = 0;

    dtc_timer i_dtc_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .count_input_0_i(cnt0),
        .count_input_1_i(cnt1), .ext_irq_pin_0_i(irq0),
        .ext_irq_pin_1_i(irq1), .irq_ack_ovf0_i(a_ovf0),
        .irq_ack_ovf1_i(a_ovf1), .irq_ack_ext0_i(a_ext0),
        .irq_ack_ext1_i(a_ext1), .overflow_flag_0_o(ovf0),
        .overflow_flag_1_o(ovf1), .ext_irq_flag_0_o(xf0),
        .ext_irq_flag_1_o(xf1), .baud_tick_o(btk));
    dtc_pins_model i_dtc_pins_model (.clk_i(clk_i),
        .count_input_0_o(cnt0), .ext_irq_pin_0_o(irq0));

    // Clock, 10 ns period
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Count baud ticks standing at each rising clock edge
    always @(posedge clk_i) begin
        if (btk === 1'b1) begin
            ticks <= ticks + 1;
        end
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One bus cycle, held until ack is sampled
    task acc(input logic w, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= {24'h0, x};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        d = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] x);
        acc(1'b1, a, x);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(d, e);
    endtask
    task tend(input int n);
        $display("test %0d done", n);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        final_report;
    end
    // Test sequence
    initial begin
        {rst_i, cyc, stb, we, a_ovf0, a_ext0, a_ovf1, a_ext1} = 8'h80;
        {cnt1, irq1} = 2'b11;
        sel = 4'h1;
        adr = 8'h00;
        dat_i = 32'h0;
        errors = 0;
        checks_done = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(8'h88, 8'h00);
        rc(8'h89, 8'h00);
        rc(8'h91, 8'h24);
        rc(8'h92, 8'h00);
        rc(8'h94, 8'h00);
        rc(8'h80, 8'h00); // unmapped place reads zero
        tend(1);
        i_dtc_pins_model.set(1'b0);
        wr(8'h8a, 8'h1e);
        wr(8'h8c, 8'hff);
        wr(8'h89, 8'h08);
        wr(8'h88, 8'h10);
        repeat (5) @(posedge clk_i);
        rc(8'h8a, 8'h1e);
        chk({7'h0, xf0}, 8'h01);
        i_dtc_pins_model.gate(3);
        rc(8'h8a, 8'h01);
        rc(8'h8c, 8'h00);
        chk({7'h0, ovf0}, 8'h01);
        tend(2);
        a_ovf0 <= 1'b1;
        @(posedge clk_i);
        a_ovf0 <= 1'b0;
        @(negedge clk_i);
        chk({7'h0, ovf0}, 8'h00);
        wr(8'h92, 8'h34);
        wr(8'h94, 8'h12);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'h89, 8'h09);
        rc(8'h89, 8'h09);
        i_dtc_pins_model.gate(3);
        rc(8'h8a, 8'h35);
        rc(8'h8c, 8'h12);
        chk({7'h0, ovf0}, 8'h01);
        tend(3);
        wr(8'h89, 8'h0a);
        wr(8'h8c, 8'h80);
        wr(8'h8a, 8'hff);
        i_dtc_pins_model.gate(2);
        rc(8'h8a, 8'h81);
        rc(8'h8c, 8'h80);
        tend(4);
        wr(8'h89, 8'h04);
        wr(8'h8a, 8'h00);
        i_dtc_pins_model.pulses(4);
        rc(8'h8a, 8'h04);
        tend(5);
        wr(8'h8b, 8'h1c);
        wr(8'h8d, 8'hff);
        wr(8'h89, 8'h34);
        wr(8'h88, 8'h50);
        repeat (10) @(posedge clk_i);
        rc(8'h8b, 8'h1c);
        wr(8'h89, 8'h04);
        repeat (10) @(posedge clk_i);
        chk({7'h0, ovf1}, 8'h01);
        chk(ticks[7:0], 8'h01);
        a_ovf1 <= 1'b1;
        @(posedge clk_i);
        a_ovf1 <= 1'b0;
        @(negedge clk_i);
        chk({7'h0, ovf1}, 8'h00);
        tend(6);
        i_dtc_pins_model.set(1'b1);
        wr(8'h88, 8'h01);
        i_dtc_pins_model.fall;
        chk({7'h0, xf0}, 8'h01);
        a_ext0 <= 1'b1;
        @(posedge clk_i);
        a_ext0 <= 1'b0;
        @(negedge clk_i);
        chk({7'h0, xf0}, 8'h00);
        irq1 <= 1'b0;
        a_ext1 <= 1'b1;
        @(posedge clk_i);
        a_ext1 <= 1'b0;
        @(negedge clk_i);
        chk({7'h0, xf1}, 8'h01);
        tend(7);
        i_dtc_pins_model.set(1'b0);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hfe);
        wr(8'h89, 8'h3b);
        wr(8'h88, 8'h40);
        repeat (5) @(posedge clk_i);
        rc(8'h8a, 8'hfe);
        chk({7'h0, ovf1}, 8'h01);
        chk({7'h0, ovf0}, 8'h00);
        wr(8'h88, 8'h50);
        i_dtc_pins_model.gate(3);
        rc(8'h8a, 8'h01);
        chk({7'h0, ovf0}, 8'h01);
        sel <= 4'h0;
        wr(8'h93, 8'h55);
        sel <= 4'h1;
        rc(8'h93, 8'h00); // byte lane 0 off, write dropped
        tend(8);
        final_report;
    end
endmodule // tb
